// File: asrh_map.svh
// Command codes, field values, status words and limits of the APDU handler
`ifndef ASRH_MAP_SVH
`define ASRH_MAP_SVH

// ****************************************************************
// Header fields
// ****************************************************************
`define ASRH_CLA_OK        8'h00
`define ASRH_INS_SELECT    8'hA4
`define ASRH_INS_READ      8'hB0
`define ASRH_P1_FID        8'h00
`define ASRH_P1_EF         8'h02
`define ASRH_P1_NAME       8'h04
`define ASRH_P2_DESIGNATE  8'h00
`define ASRH_P2_NO_FCI     8'h0C
`define ASRH_P1P2_EF       16'h020C
`define ASRH_P1P2_APP      16'h0400
`define ASRH_P1P2_FID      16'h000C

// ****************************************************************
// Lengths and file identifiers
// ****************************************************************
`define ASRH_LC_APP        8'h07
`define ASRH_LC_FID        8'h02
`define ASRH_LE_APP        8'h00
`define ASRH_FID_CC        16'hE103
`define ASRH_FID_NDEF      16'h0103
`define ASRH_READ_MIN      8'h01
`define ASRH_READ_MAX      8'hFB
`define ASRH_ENC_MAX_N     4'hF
// Arbitrary application identifier, not any real product value
`define ASRH_APP_ID        56'hA5_0102_0304_0506
// Byte counts of whole command frames, and the value where the received-byte count stops
`define ASRH_CNT_READ      4'h5
`define ASRH_CNT_FID       4'h7
`define ASRH_CNT_APP       4'hD
`define ASRH_CNT_SAT       4'hF

// ****************************************************************
// Status words
// ****************************************************************
`define ASRH_SW_OK         16'h9000
`define ASRH_SW_ERR_CLA    16'h6E00
`define ASRH_SW_ERR_INS    16'h6D00
`define ASRH_SW_ERR_P1P2   16'h6A86
`define ASRH_SW_ERR_LEN    16'h6700
`define ASRH_SW_ERR_DATA   16'h6A82

`endif

// File: asrh_pkg.sv
// Types shared by both ends of the APDU select/read link
package asrh_pkg;

  typedef enum logic [1:0] {
    DS_RECV = 2'b00,
    DS_EVAL = 2'b01,
    DS_LOAD = 2'b10,
    DS_RESP = 2'b11
  } asrh_dev_state_t;

  typedef enum logic [2:0] {
    FILE_NONE = 3'b000,
    FILE_APP  = 3'b001,
    FILE_CC   = 3'b010,
    FILE_NDEF = 3'b011,
    FILE_EF   = 3'b100
  } asrh_file_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SEND = 2'b01,
    HS_RECV = 2'b10
  } asrh_host_state_t;

  typedef enum logic [2:0] {
    RQ_APP    = 3'b000,
    RQ_CC     = 3'b001,
    RQ_NDEF   = 3'b010,
    RQ_EF_FID = 3'b011,
    RQ_EF_DIR = 3'b100,
    RQ_READ   = 3'b101
  } asrh_req_t;

  typedef struct packed {
    asrh_dev_state_t  st;
    logic [3:0]       cnt;
    logic [12:0][7:0] buff;
    asrh_file_t       sel;
    logic [15:0]      efId;
    logic [15:0]      sw;
    logic [7:0]       left;
    logic [15:0]      addr;
    logic             swHiSent;
    logic [7:0]       rspByte;
    logic             rspLast;
    logic             done;
  } asrh_dev_regs_t;

  typedef struct packed {
    asrh_host_state_t st;
    asrh_req_t        kind;
    logic [15:0]      fid;
    logic [15:0]      addr;
    logic [7:0]       len;
    logic [3:0]       idx;
    logic [3:0]       total;
    logic [7:0]       txByte;
    logic [1:0][7:0]  hist;
    logic [1:0]       histCnt;
    logic             refused;
    logic             rdValid;
    logic [7:0]       rdData;
    logic             done;
    logic [15:0]      sw;
  } asrh_host_regs_t;

endpackage

// File: asrh_if.sv
// Byte-stream link between the reader end and the tag end
`timescale 1ns/1ns
`default_nettype none

interface asrh_if;
  logic       cmdValid;
  logic       cmdReady;
  logic [7:0] cmdData;
  logic       cmdLast;
  logic       rspValid;
  logic       rspReady;
  logic [7:0] rspData;
  logic       rspLast;

  modport dev (
    input  cmdValid, cmdData, cmdLast, rspReady,
    output cmdReady, rspValid, rspData, rspLast
  );

  modport host (
    output cmdValid, cmdData, cmdLast, rspReady,
    input  cmdReady, rspValid, rspData, rspLast
  );
endinterface

`default_nettype wire

// File: asrh_dev.sv
// Tag end: decodes SELECT and READ commands and answers them
`timescale 1ns/1ns
`default_nettype none
`include "asrh_map.svh"

module asrh_dev #(
  parameter logic [55:0] APP_ID = `ASRH_APP_ID
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Link to the reader
  asrh_if.dev                    link,
  // Stored-data read port, combinational answer
  output logic [15:0]            memAddr,
  input  wire logic [7:0]        memRdata,
  // Selection and command status
  output asrh_pkg::asrh_file_t   selFile,
  output logic [15:0]            selEfId,
  output logic                   cmdDone,
  output logic [15:0]            cmdSw
);

  asrh_pkg::asrh_dev_regs_t q;
  asrh_pkg::asrh_dev_regs_t d;

  // ****************************************************************
  // Field views of the received frame
  // ****************************************************************
  logic [7:0]  cla;
  logic [7:0]  ins;
  logic [15:0] p1p2;
  logic [7:0]  lc;
  logic [15:0] fid;
  logic [55:0] aid;
  logic        isApp;
  logic        loadNext;

  assign cla   = q.buff[0];
  assign ins   = q.buff[1];
  assign p1p2  = {q.buff[2], q.buff[3]};
  assign lc    = q.buff[4];
  assign fid   = {q.buff[5], q.buff[6]};
  assign aid   = {q.buff[5], q.buff[6], q.buff[7], q.buff[8],
                  q.buff[9], q.buff[10], q.buff[11]};
  assign isApp = (p1p2 == `ASRH_P1P2_APP);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    d        = q;
    d.done   = 1'b0;
    loadNext = 1'b0;
    case (q.st)
      asrh_pkg::DS_RECV:
      begin
        if (link.cmdValid)
        begin
          // Bytes past the longest frame are counted, not stored
          if (q.cnt < `ASRH_CNT_APP)
            d.buff[q.cnt] = link.cmdData;
          if (q.cnt != `ASRH_CNT_SAT)
            d.cnt = q.cnt + 4'h1;
          if (link.cmdLast)
            d.st = asrh_pkg::DS_EVAL;
        end
      end
      asrh_pkg::DS_EVAL:
      begin
        d.sw = `ASRH_SW_OK;
        if (cla != `ASRH_CLA_OK)
          d.sw = `ASRH_SW_ERR_CLA;
        else if (ins == `ASRH_INS_SELECT)
        begin
          if (p1p2 != `ASRH_P1P2_EF && !isApp &&
              p1p2 != `ASRH_P1P2_FID)
            d.sw = `ASRH_SW_ERR_P1P2;
          else if (lc != (isApp ? `ASRH_LC_APP : `ASRH_LC_FID))
            d.sw = `ASRH_SW_ERR_LEN;
          else if (q.cnt != (isApp ? `ASRH_CNT_APP : `ASRH_CNT_FID))
            d.sw = `ASRH_SW_ERR_LEN;
          else if (isApp && q.buff[12] != `ASRH_LE_APP)
            d.sw = `ASRH_SW_ERR_LEN;
          else if (isApp && aid != APP_ID)
            d.sw = `ASRH_SW_ERR_DATA;
        end
        else if (ins == `ASRH_INS_READ)
        begin
          if (q.cnt != `ASRH_CNT_READ)
            d.sw = `ASRH_SW_ERR_LEN;
          else if (lc < `ASRH_READ_MIN || lc > `ASRH_READ_MAX)
            d.sw = `ASRH_SW_ERR_LEN;
        end
        else
          d.sw = `ASRH_SW_ERR_INS;

        // Selection only moves on a fully accepted SELECT
        if (d.sw == `ASRH_SW_OK && ins == `ASRH_INS_SELECT)
        begin
          if (isApp)
            d.sel = asrh_pkg::FILE_APP;
          else if (p1p2 == `ASRH_P1P2_EF)
          begin
            d.sel  = asrh_pkg::FILE_EF;
            d.efId = fid;
          end
          else if (fid == `ASRH_FID_CC)
            d.sel = asrh_pkg::FILE_CC;
          else if (fid == `ASRH_FID_NDEF)
            d.sel = asrh_pkg::FILE_NDEF;
          else
          begin
            // Reader is expected to use only free identifiers here
            d.sel  = asrh_pkg::FILE_EF;
            d.efId = fid;
          end
        end

        // SELECT never carries control info, only the status word
        if (d.sw == `ASRH_SW_OK && ins == `ASRH_INS_READ)
          d.left = lc;
        else
          d.left = 8'h00;
        d.addr     = p1p2;
        d.swHiSent = 1'b0;
        d.st       = asrh_pkg::DS_LOAD;
      end
      asrh_pkg::DS_LOAD:
      begin
        loadNext = 1'b1;
        d.st     = asrh_pkg::DS_RESP;
      end
      asrh_pkg::DS_RESP:
      begin
        if (link.rspReady)
        begin
          if (q.rspLast)
          begin
            d.st   = asrh_pkg::DS_RECV;
            d.cnt  = 4'h0;
            d.buff = '0;
            d.done = 1'b1;
          end
          else
            loadNext = 1'b1;
        end
      end
      default:
        d.st = asrh_pkg::DS_RECV;
    endcase

    // Data bytes first, then the two status bytes
    if (loadNext)
    begin
      if (q.left != 8'h00)
      begin
        d.rspByte = memRdata;
        d.rspLast = 1'b0;
        d.addr    = q.addr + 16'h0001;
        d.left    = q.left - 8'h01;
      end
      else if (!q.swHiSent)
      begin
        d.rspByte  = q.sw[15:8];
        d.rspLast  = 1'b0;
        d.swHiSent = 1'b1;
      end
      else
      begin
        d.rspByte = q.sw[7:0];
        d.rspLast = 1'b1;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      q     <= '0;
      q.st  <= asrh_pkg::DS_RECV;
      q.sel <= asrh_pkg::FILE_NONE;
    end
    else
      q <= d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.cmdReady = (q.st == asrh_pkg::DS_RECV);
  assign link.rspValid = (q.st == asrh_pkg::DS_RESP);
  assign link.rspData  = q.rspByte;
  assign link.rspLast  = q.rspLast;
  assign memAddr       = q.addr;
  assign selFile       = q.sel;
  assign selEfId       = q.efId;
  assign cmdDone       = q.done;
  assign cmdSw         = q.sw;

endmodule // asrh_dev

`default_nettype wire

// File: asrh_host.sv
// Reader end: builds SELECT and READ frames and splits the answers
`timescale 1ns/1ns
`default_nettype none
`include "asrh_map.svh"

module asrh_host #(
  parameter logic [55:0] APP_ID = `ASRH_APP_ID
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // Link to the tag
  asrh_if.host                     link,
  // Request from the user
  input  wire logic                reqValid,
  output logic                     reqReady,
  input  wire asrh_pkg::asrh_req_t reqKind,
  input  wire logic [15:0]         reqFileId,
  input  wire logic [15:0]         reqAddr,
  input  wire logic [7:0]          reqLen,
  input  wire logic                reqEncrypted,
  // Results to the user
  output logic                     reqRefused,
  output logic                     rdValid,
  output logic [7:0]               rdData,
  output logic                     doneValid,
  output logic [15:0]              doneSw
);

  asrh_pkg::asrh_host_regs_t q;
  asrh_pkg::asrh_host_regs_t d;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic reqLegal(asrh_pkg::asrh_req_t k,
                                    logic [15:0] f, logic [7:0] n,
                                    logic enc);
    logic ok;
    ok = 1'b1;
    if (k == asrh_pkg::RQ_READ)
    begin
      ok = (n >= `ASRH_READ_MIN) && (n <= `ASRH_READ_MAX);
      // Encrypted length is 16 x m with m up to the limit
      if (enc)
        ok = ok && (n[3:0] == 4'h0) && (n[7:4] <= `ASRH_ENC_MAX_N);
    end
    else if (k == asrh_pkg::RQ_EF_FID)
      ok = (f != `ASRH_FID_CC) && (f != `ASRH_FID_NDEF);
    return ok;
  endfunction

  function automatic logic [7:0] cmdByte(asrh_pkg::asrh_req_t k,
                                         logic [15:0] f, logic [15:0] a,
                                         logic [7:0] n, logic [3:0] i);
    logic        rd;
    logic        app;
    logic [55:0] sh;
    logic [7:0]  b;
    rd  = (k == asrh_pkg::RQ_READ);
    app = (k == asrh_pkg::RQ_APP);
    sh  = APP_ID << {i - 4'h5, 3'b000};
    b   = 8'h00;
    case (i)
      4'h0: b = `ASRH_CLA_OK;
      4'h1: b = rd ? `ASRH_INS_READ : `ASRH_INS_SELECT;
      4'h2: b = rd ? a[15:8] : app ? `ASRH_P1_NAME :
                (k == asrh_pkg::RQ_EF_DIR) ? `ASRH_P1_EF : `ASRH_P1_FID;
      4'h3: b = rd ? a[7:0] : app ? `ASRH_P2_DESIGNATE : `ASRH_P2_NO_FCI;
      4'h4: b = rd ? n : app ? `ASRH_LC_APP : `ASRH_LC_FID;
      4'hC: b = `ASRH_LE_APP;
      default:
        b = app ? sh[55:48] : (i == 4'h5) ? f[15:8] : f[7:0];
    endcase
    return b;
  endfunction

  logic [15:0] fidNow;
  logic [3:0]  nextIdx;

  always_comb
  begin
    case (reqKind)
      asrh_pkg::RQ_CC:   fidNow = `ASRH_FID_CC;
      asrh_pkg::RQ_NDEF: fidNow = `ASRH_FID_NDEF;
      default:           fidNow = reqFileId;
    endcase
  end

  assign nextIdx = q.idx + 4'h1;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    d         = q;
    d.refused = 1'b0;
    d.rdValid = 1'b0;
    d.done    = 1'b0;
    case (q.st)
      asrh_pkg::HS_IDLE:
      begin
        if (reqValid)
        begin
          if (!reqLegal(reqKind, reqFileId, reqLen, reqEncrypted))
            d.refused = 1'b1;
          else
          begin
            d.kind    = reqKind;
            d.fid     = fidNow;
            d.addr    = reqAddr;
            d.len     = reqLen;
            d.idx     = 4'h0;
            d.histCnt = 2'b00;
            d.txByte  = cmdByte(reqKind, fidNow, reqAddr, reqLen, 4'h0);
            if (reqKind == asrh_pkg::RQ_READ)
              d.total = `ASRH_CNT_READ;
            else if (reqKind == asrh_pkg::RQ_APP)
              d.total = `ASRH_CNT_APP;
            else
              d.total = `ASRH_CNT_FID;
            d.st = asrh_pkg::HS_SEND;
          end
        end
      end
      asrh_pkg::HS_SEND:
      begin
        if (link.cmdReady)
        begin
          d.idx    = nextIdx;
          d.txByte = cmdByte(q.kind, q.fid, q.addr, q.len, nextIdx);
          if (nextIdx == q.total)
            d.st = asrh_pkg::HS_RECV;
        end
      end
      asrh_pkg::HS_RECV:
      begin
        if (link.rspValid)
        begin
          // Last two bytes are the status word, so hold two back
          if (q.histCnt == 2'b10)
          begin
            d.rdValid = 1'b1;
            d.rdData  = q.hist[1];
          end
          d.hist = {q.hist[0], link.rspData};
          if (q.histCnt != 2'b10)
            d.histCnt = q.histCnt + 2'b01;
          if (link.rspLast)
          begin
            d.sw   = {q.hist[0], link.rspData};
            d.done = 1'b1;
            d.st   = asrh_pkg::HS_IDLE;
          end
        end
      end
      default:
        d.st = asrh_pkg::HS_IDLE;
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      q      <= '0;
      q.st   <= asrh_pkg::HS_IDLE;
      q.kind <= asrh_pkg::RQ_APP;
    end
    else
      q <= d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reqReady      = (q.st == asrh_pkg::HS_IDLE);
  assign link.cmdValid = (q.st == asrh_pkg::HS_SEND);
  assign link.cmdData  = q.txByte;
  assign link.cmdLast  = (nextIdx == q.total);
  assign link.rspReady = (q.st == asrh_pkg::HS_RECV);
  assign reqRefused    = q.refused;
  assign rdValid       = q.rdValid;
  assign rdData        = q.rdData;
  assign doneValid     = q.done;
  assign doneSw        = q.sw;

endmodule // asrh_host

`default_nettype wire

// File: asrh_chk.sv
// Link checker for the reader-to-tag and tag-to-reader byte streams
`timescale 1ns/1ns
`default_nettype none
`include "asrh_map.svh"

module asrh_chk (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Link signals
  input wire logic       cmdValid,
  input wire logic       cmdReady,
  input wire logic [7:0] cmdData,
  input wire logic       cmdLast,
  input wire logic       rspValid,
  input wire logic       rspReady,
  input wire logic [7:0] rspData,
  input wire logic       rspLast
);
  localparam logic [15:0] SW_OK = `ASRH_SW_OK;
  logic       cTake;
  logic       rTake;
  logic [3:0] idx_q;
  logic [7:0] ins_q;
  logic [7:0] le_q;
  logic [7:0] cnt_q;
  logic [7:0] prev_q;
  assign cTake = cmdValid && cmdReady;
  assign rTake = rspValid && rspReady;

  // Frame position, command fields and response byte count
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      idx_q <= 4'h0;
      ins_q <= 8'h00;
      le_q <= 8'h00;
      cnt_q <= 8'h00;
      prev_q <= 8'h00;
    end
    else
    begin
      if (cTake)
        idx_q <= cmdLast ? 4'h0 : idx_q + 4'h1;
      if (cTake && idx_q == 4'h1)
        ins_q <= cmdData;
      if (cTake && idx_q == 4'h4)
        le_q <= cmdData;
      if (rTake)
        cnt_q <= rspLast ? 8'h00 : cnt_q + 8'h01;
      if (rTake)
        prev_q <= rspData;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_rsp_latency: assert property (cTake && cmdLast |-> ##3 rspValid)
    else $error("response not three cycles after frame end");
  a_busy_after_last: assert property (cTake && cmdLast |=> !cmdReady)
    else $error("command accepted while evaluating");
  a_rsp_not_recv: assert property (rspValid |-> !cmdReady)
    else $error("response shown while receiving");
  a_recv_after_sw: assert property (rTake && rspLast |=>
    cmdReady && !rspValid)
    else $error("no return to receive after status");
  a_cmd_one_frame: assert property (cmdValid |-> cmdReady)
    else $error("command byte offered while busy");
  a_sel_two_bytes: assert property (rTake && rspLast &&
    ins_q == `ASRH_INS_SELECT |-> cnt_q == 8'h01)
    else $error("select answer not two bytes");
  a_read_length: assert property (rTake && rspLast &&
    ins_q == `ASRH_INS_READ |-> cnt_q == le_q + 8'h01)
    else $error("read answer length wrong");
  a_read_status: assert property (rTake && rspLast &&
    ins_q == `ASRH_INS_READ |-> {prev_q, rspData} == SW_OK)
    else $error("legal read not completed normally");

  c_select: cover property (rTake && rspLast && ins_q == `ASRH_INS_SELECT);
  c_read: cover property (rTake && rspLast && ins_q == `ASRH_INS_READ);
  c_read_max: cover property (rTake && rspLast && le_q == `ASRH_READ_MAX);
endmodule // asrh_chk

`default_nettype wire

// File: tb_apdu_select_read_handler.sv
// Bench: both ends joined, plus a raw reader driving a second tag end
`timescale 1ns/1ns
`default_nettype none
`include "asrh_map.svh"

module tb_apdu_select_read_handler;
  typedef logic [7:0] asrh_bytes_t[$];
  localparam logic [15:0] OK = `ASRH_SW_OK;
  localparam logic [15:0] E_LEN = `ASRH_SW_ERR_LEN;
  localparam logic [55:0] AID = `ASRH_APP_ID;
  localparam asrh_pkg::asrh_file_t F_CC = asrh_pkg::FILE_CC;
  localparam asrh_pkg::asrh_file_t F_EF = asrh_pkg::FILE_EF;
  localparam asrh_pkg::asrh_req_t RD = asrh_pkg::RQ_READ;
  logic core_clk, rst, reqValid, reqReady, reqEnc, reqRefused, rdValid;
  logic doneValid, cmdDoneA, cmdDoneB;
  logic [7:0] reqLen, rdData, memRdA, memRdB;
  logic [15:0] reqFid, reqAddr, doneSw, memAddrA, memAddrB;
  logic [15:0] efIdA, efIdB, cmdSwA, cmdSwB;
  asrh_pkg::asrh_req_t reqKind;
  asrh_pkg::asrh_file_t selA, selB;
  asrh_bytes_t aidQ, badQ;
  logic [15:0] badPair [4];
  int err_total, n_compared, i;
  asrh_if ifA ();
  asrh_if ifB ();

  function automatic logic [7:0] memf(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  assign memRdA = memf(memAddrA);
  assign memRdB = memf(memAddrB);

  asrh_dev u_asrh_dev (.core_clk(core_clk), .rst(rst), .link(ifA),
    .memAddr(memAddrA), .memRdata(memRdA), .selFile(selA),
    .selEfId(efIdA), .cmdDone(cmdDoneA), .cmdSw(cmdSwA));
  asrh_host u_asrh_host (.core_clk(core_clk), .rst(rst), .link(ifA),
    .reqValid(reqValid), .reqReady(reqReady), .reqKind(reqKind),
    .reqFileId(reqFid), .reqAddr(reqAddr), .reqLen(reqLen),
    .reqEncrypted(reqEnc), .reqRefused(reqRefused), .rdValid(rdValid),
    .rdData(rdData), .doneValid(doneValid), .doneSw(doneSw));
  asrh_dev u_asrh_dev_b (.core_clk(core_clk), .rst(rst), .link(ifB),
    .memAddr(memAddrB), .memRdata(memRdB), .selFile(selB),
    .selEfId(efIdB), .cmdDone(cmdDoneB), .cmdSw(cmdSwB));
  asrh_chk u_asrh_chk (.core_clk(core_clk), .rst(rst),
    .cmdValid(ifA.cmdValid), .cmdReady(ifA.cmdReady),
    .cmdData(ifA.cmdData), .cmdLast(ifA.cmdLast),
    .rspValid(ifA.rspValid), .rspReady(ifA.rspReady),
    .rspData(ifA.rspData), .rspLast(ifA.rspLast));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  // Host-side request; sw of zero means the request must be refused
  task automatic hreq(input asrh_pkg::asrh_req_t kd, input logic [15:0] v,
    input logic [7:0] len, input logic enc, input logic [15:0] sw,
    input asrh_pkg::asrh_file_t f);
    int k;
    int n;
    n = 0;
    @(negedge core_clk);
    chk("reqReady", 16'h1, {15'h0, reqReady});
    reqValid = 1'b1;
    reqKind  = kd;
    reqFid   = v;
    reqAddr  = v;
    reqLen   = len;
    reqEnc   = enc;
    @(negedge core_clk);
    reqValid = 1'b0;
    for (k = 0; k < 3000; k++)
    begin
      if (rdValid === 1'b1)
      begin
        chk("rdData", {8'h00, memf(v + n[15:0])}, {8'h00, rdData});
        n++;
      end
      if (reqRefused === 1'b1 || doneValid === 1'b1)
        break;
      @(negedge core_clk);
    end
    if (k == 3000)
    begin
      err_total++;
      stop_test;
    end
    chk("refused", {15'h0, sw == 16'h0}, {15'h0, reqRefused});
    if (sw != 16'h0)
    begin
      chk("doneSw", sw, doneSw);
      chk("cmdSwA", sw, cmdSwA);
      chk("cmdDoneA", 16'h1, {15'h0, cmdDoneA});
    end
    chk("rdCount", (kd == RD && sw == OK) ? {8'h00, len} : 16'h0,
      n[15:0]);
    chk("selFile", {13'h0, f}, {13'h0, selA});
  endtask

  // Raw frame into the second tag end; errors answer status only
  task automatic raw(input asrh_bytes_t q, input logic [15:0] sw,
    input asrh_pkg::asrh_file_t f);
    int k;
    int n;
    logic [15:0] got;
    n = 0;
    got = 16'h0;
    foreach (q[j])
    begin
      @(negedge core_clk);
      ifB.cmdValid = 1'b1;
      ifB.cmdData  = q[j];
      ifB.cmdLast  = (j == q.size() - 1);
    end
    @(negedge core_clk);
    {ifB.cmdValid, ifB.cmdLast, ifB.rspReady} = 3'b001;
    ifB.cmdData = ~ifB.cmdData;
    for (k = 0; k < 600; k++)
    begin
      @(negedge core_clk);
      if (ifB.rspValid === 1'b1)
      begin
        got = {got[7:0], ifB.rspData};
        n++;
        if (ifB.rspLast === 1'b1)
          break;
      end
    end
    if (k == 600)
    begin
      err_total++;
      stop_test;
    end
    @(negedge core_clk);
    ifB.rspReady = 1'b0;
    chk("rawDone", 16'h1, {15'h0, cmdDoneB});
    chk("rawCmdSw", sw, cmdSwB);
    chk("rawSw", sw, got);
    chk("rawCount", 16'h2, n[15:0]);
    chk("rawSel", {13'h0, f}, {13'h0, selB});
  endtask

  initial
  begin
    {reqValid, reqEnc, reqFid, reqAddr, reqLen} = 42'h0;
    reqKind = asrh_pkg::RQ_APP;
    rst = 1'b1;
    {ifB.cmdValid, ifB.cmdData, ifB.cmdLast, ifB.rspReady} = 11'h0;
    err_total = 0;
    n_compared = 0;
    badPair = '{16'h0000, 16'h0200, 16'h040C, 16'h0100};
    for (i = 0; i < 7; i++)
      aidQ.push_back(AID[55 - 8 * i -: 8]);
    badQ = aidQ;
    badQ[6] = ~badQ[6];
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    hreq(asrh_pkg::RQ_APP, 16'h0, 8'h0, 1'b0, OK, asrh_pkg::FILE_APP);
    hreq(asrh_pkg::RQ_CC, 16'h0, 8'h0, 1'b0, OK, F_CC);
    hreq(asrh_pkg::RQ_NDEF, 16'h0, 8'h0, 1'b0, OK,
      asrh_pkg::FILE_NDEF);
    hreq(asrh_pkg::RQ_EF_FID, 16'h1234, 8'h0, 1'b0, OK, F_EF);
    chk("efId", 16'h1234, efIdA);
    hreq(asrh_pkg::RQ_EF_FID, 16'hE103, 8'h0, 1'b0, 16'h0, F_EF);
    hreq(asrh_pkg::RQ_EF_DIR, 16'h0103, 8'h0, 1'b0, OK, F_EF);
    chk("efId", 16'h0103, efIdA);
    hreq(RD, 16'h0180, 8'h01, 1'b0, OK, F_EF);
    hreq(RD, 16'hFFF0, 8'hFB, 1'b0, OK, F_EF);
    hreq(RD, 16'h0010, 8'h00, 1'b0, 16'h0, F_EF);
    hreq(RD, 16'h0010, 8'hFC, 1'b0, 16'h0, F_EF);
    hreq(RD, 16'h0020, 8'h20, 1'b1, OK, F_EF);
    hreq(RD, 16'h0020, 8'h14, 1'b1, 16'h0, F_EF);
    raw('{8'h00, 8'hA4, 8'h00, 8'h0C, 8'h02, 8'hE1, 8'h03}, OK, F_CC);
    raw('{8'h01, 8'hA4, 8'h00, 8'h0C, 8'h02, 8'hE1, 8'h03},
      16'h6E00, F_CC);
    raw('{8'h80, 8'hB0, 8'h00, 8'h00, 8'h01}, 16'h6E00, F_CC);
    raw('{8'h01, 8'hA5, 8'h00, 8'h0C, 8'h02, 8'h01, 8'h03},
      16'h6E00, F_CC);
    raw('{8'h00, 8'hA5, 8'h00, 8'h0C, 8'h02, 8'h01, 8'h03},
      16'h6D00, F_CC);
    for (i = 0; i < 4; i++)
      raw('{8'h00, 8'hA4, badPair[i][15:8], badPair[i][7:0], 8'h02, 8'h01,
        8'h03}, 16'h6A86, F_CC);
    raw('{8'h00, 8'hA4, 8'h00, 8'h0C, 8'h03, 8'h01, 8'h03},
      E_LEN, F_CC);
    raw('{8'h00, 8'hA4, 8'h04, 8'h00, 8'h02, 8'h01, 8'h03},
      E_LEN, F_CC);
    raw('{8'h00, 8'hA4, 8'h00, 8'h0C, 8'h02, 8'h01, 8'h03, 8'h00},
      E_LEN, F_CC);
    raw({8'h00, 8'hA4, 8'h04, 8'h00, 8'h07, aidQ, 8'h01},
      E_LEN, F_CC);
    raw({8'h00, 8'hA4, 8'h04, 8'h00, 8'h07, aidQ}, E_LEN, F_CC);
    raw({8'h00, 8'hA4, 8'h04, 8'h00, 8'h07, badQ, 8'h00},
      16'h6A82, F_CC);
    raw('{8'h00, 8'hB0, 8'h00, 8'h10, 8'h00}, E_LEN, F_CC);
    raw('{8'h00, 8'hB0, 8'h00, 8'h10, 8'hFC}, E_LEN, F_CC);
    raw('{8'h00, 8'hA4, 8'h02, 8'h0C, 8'h02, 8'hE1, 8'h03}, OK, F_EF);
    chk("efIdB", 16'hE103, efIdB);
    stop_test;
  end
endmodule // tb_apdu_select_read_handler

`default_nettype wire
